// >>> src/pixel_serializer_7to1.sv
// 7:1 pixel serializer: captures a 21-bit word per pixel clock fall and
// sends it over three data lanes plus a forwarded clock lane.
// Assumes the pixel clock pin and word pins are asynchronous to clock and
// that the word is held stable for several system cycles around each fall.
//
// Contract
// [R01] Every pixel clock cycle the whole 21-bit word is captured and sent; code drops and flags a word that finds the FIFO full.
// [R02] The 21 bits spread over three lanes, seven bits per lane per word.
// [R03] A clock copy runs on a fourth lane beside the data lanes.
// [R04] Source supplies 18 colour bits plus line sync, frame sync, valid.
// [R05] Word sampled only on the falling edge of the pixel clock.
// [R06] Power up but no input clock: all lanes and clock driven low.
// [R07] Power-down low: lanes and clock high-impedance, standby entered.
// [R08] Power-down assertion is held at least 1 us by the controller.
// [R09] Outputs disabled within 100 ns of power-down assertion.
// [R10] With clock present and power up, valid output within 10 ms.
// [R11] Pixel clock from 18 to 68 MHz supported, source stays in range; code samples pins at 10 MHz and drains one word per 700 ns.
// [R12] Seven bit slots per lane per word, slot k at k sevenths.
// [R13] Spread-spectrum clock up to 100 kHz modulation is tracked.
// [R14] No start-up order among clock, data and power-down is required.
// [R15] Power-down resets internal state and drops lock; relock on release.
// [R16] Stopped then resumed clock recovers without cycling power-down.
// [R17] Fixed bit map: lane n slot k carries word bit 7n+k.
`timescale 1ns/100ps
module pixel_serializer_7to1 #(
    parameter int LOCK_TIME_LIMIT_CYCLES = pixel_serializer_pkg::LOCK_TIME_LIMIT_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pixel_shift_clock_pin,
    input wire logic [20:0] pixel_input_bits,
    input wire logic power_down_n,
    output logic [2:0] serial_data_lanes,
    output logic serial_data_lanes_oe,
    output logic forwarded_link_clock,
    output logic forwarded_link_clock_oe,
    output logic link_locked,
    output logic standby_active,
    output logic capture_overrun
);
    localparam int WB = pixel_serializer_pkg::WORD_BITS;
    localparam int SL = pixel_serializer_pkg::SLOTS;

    logic [2:0] clk_sync_reg;
    logic [2:0] pd_sync_reg;
    logic [WB-1:0] pix_s1_reg;
    logic [WB-1:0] pix_s2_reg;
    logic [WB-1:0] pix_s3_reg;
    logic clk_lvl_reg;
    logic pd_lvl_reg;
    logic fall_pulse;
    logic [5:0] idle_cnt_reg;
    logic clock_present;
    logic [6:0] lock_cnt_reg;
    pixel_serializer_pkg::link_state_e state_reg;
    pixel_serializer_pkg::link_state_e state_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic fifo_flush;
    logic [WB-1:0] fifo_out_data;
    logic [WB-1:0] word_reg;
    logic [2:0] slot_reg;
    logic busy_reg;
    logic [2:0] lane_next;
    logic [2:0] lane_out_reg;
    logic clk_out_reg;
    logic drive_en_reg;
    logic overrun_reg;
    logic [16:0] wait_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages each; data follows the clock's path
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_sync_reg <= 3'h0;
            pd_sync_reg <= 3'h0;
            pix_s1_reg <= '0;
            pix_s2_reg <= '0;
            pix_s3_reg <= '0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], pixel_shift_clock_pin};
            pd_sync_reg <= {pd_sync_reg[1:0], power_down_n};
            pix_s1_reg <= pixel_input_bits;
            pix_s2_reg <= pix_s1_reg;
            pix_s3_reg <= pix_s2_reg;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_lvl_reg <= 1'b0;
            pd_lvl_reg <= 1'b0;
        end else begin
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_lvl_reg <= clk_sync_reg[2];
            end
            if (pd_sync_reg[1] == pd_sync_reg[2]) begin
                pd_lvl_reg <= pd_sync_reg[2];
            end
        end
    end

    // Only the falling edge strobes the word [R05]
    assign fall_pulse = clk_lvl_reg && (clk_sync_reg[1] == clk_sync_reg[2]) && !clk_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // Clock detection; each falling edge restarts the watch, so slow drift of a
    // spread clock is followed edge by edge [R13]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_reg <= pixel_serializer_pkg::CLK_LOSS_CYCLES;
        end else if (fall_pulse) begin
            idle_cnt_reg <= 6'h00;
        end else if (idle_cnt_reg != pixel_serializer_pkg::CLK_LOSS_CYCLES) begin
            idle_cnt_reg <= idle_cnt_reg + 6'h01;
        end
    end

    // Timeout sits well above the slowest supported pixel period [R11]
    assign clock_present = idle_cnt_reg != pixel_serializer_pkg::CLK_LOSS_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // Link state; any order of clock and power-down reaches run [R14]
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pixel_serializer_pkg::st_standby: begin
                state_next = pixel_serializer_pkg::st_no_clock;
            end
            pixel_serializer_pkg::st_no_clock: begin
                if (clock_present) begin
                    state_next = pixel_serializer_pkg::st_locking;
                end
            end
            pixel_serializer_pkg::st_locking: begin
                if (!clock_present) begin
                    state_next = pixel_serializer_pkg::st_no_clock;
                end else if (lock_cnt_reg == pixel_serializer_pkg::LOCK_SETTLE_CYCLES) begin
                    state_next = pixel_serializer_pkg::st_run;
                end
            end
            pixel_serializer_pkg::st_run: begin
                // A lost clock drops back and relocks on its own [R16]
                if (!clock_present) begin
                    state_next = pixel_serializer_pkg::st_no_clock;
                end
            end
        endcase
        // Power-down overrides everything and resets the link [R15]
        if (!pd_lvl_reg) begin
            state_next = pixel_serializer_pkg::st_standby;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= pixel_serializer_pkg::st_standby;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock settle counter, cleared outside the locking state [R10]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_cnt_reg <= 7'h00;
        end else if (state_reg != pixel_serializer_pkg::st_locking) begin
            lock_cnt_reg <= 7'h00;
        end else if (lock_cnt_reg != pixel_serializer_pkg::LOCK_SETTLE_CYCLES) begin
            lock_cnt_reg <= lock_cnt_reg + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture into the FIFO; a full FIFO drops the strobed word and flags the loss
    assign fifo_flush = state_reg != pixel_serializer_pkg::st_run;
    assign fifo_in_valid = fall_pulse && (state_reg == pixel_serializer_pkg::st_run); // [R01]
    assign fifo_out_ready = !busy_reg || (slot_reg == pixel_serializer_pkg::LAST_SLOT);

    pixel_word_fifo #(
        .WIDTH(WB),
        .DEPTH(pixel_serializer_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pix_s3_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Overrun pulse: a strobe that found the FIFO full
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= fifo_in_valid && !fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot sequencer: one slot per system cycle, seven per word [R12]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            slot_reg <= 3'h0;
            word_reg <= '0;
        end else if (fifo_flush) begin
            busy_reg <= 1'b0;
            slot_reg <= 3'h0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            busy_reg <= 1'b1;
            slot_reg <= 3'h0;
            word_reg <= fifo_out_data;
        end else if (busy_reg && slot_reg == pixel_serializer_pkg::LAST_SLOT) begin
            busy_reg <= 1'b0;
            slot_reg <= 3'h0;
        end else if (busy_reg) begin
            slot_reg <= slot_reg + 3'h1;
        end
    end

    // Lane n slot k carries word bit 7n+k [R02] [R17]
    for (genvar l = 0; l < pixel_serializer_pkg::LANES; l++) begin : g_lane
        assign lane_next[l] = word_reg[l * SL + int'(slot_reg)];
    end

    // Output stage; idle lanes sit low, which also covers a missing clock [R06]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lane_out_reg <= 3'h0;
            clk_out_reg <= 1'b0;
        end else if (busy_reg) begin
            lane_out_reg <= lane_next;
            clk_out_reg <= pixel_serializer_pkg::CLK_SLOT_PATTERN[slot_reg]; // [R03]
        end else begin
            lane_out_reg <= 3'h0;
            clk_out_reg <= 1'b0;
        end
    end

    // Drivers stay on in every state except standby [R07]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_en_reg <= 1'b0;
        end else begin
            drive_en_reg <= state_next != pixel_serializer_pkg::st_standby;
        end
    end

    // Enables are gated by the raw pin: the synchroniser alone would take
    // longer than the 100 ns allowed, and dropping a driver is glitch safe
    assign serial_data_lanes_oe = drive_en_reg && power_down_n; // [R09]
    assign forwarded_link_clock_oe = drive_en_reg && power_down_n; // [R09]
    assign serial_data_lanes = lane_out_reg;
    assign forwarded_link_clock = clk_out_reg;
    assign link_locked = state_reg == pixel_serializer_pkg::st_run;
    assign standby_active = state_reg == pixel_serializer_pkg::st_standby;
    assign capture_overrun = overrun_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks; helper counts cycles from power up with clock present
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_reg <= 17'h00000;
        end else if (state_reg == pixel_serializer_pkg::st_run || !clock_present || !pd_lvl_reg) begin
            wait_cnt_reg <= 17'h00000;
        end else if (wait_cnt_reg != 17'h1FFFF) begin
            wait_cnt_reg <= wait_cnt_reg + 17'h00001;
        end
    end

    property p_pd_tristate;
        @(posedge clock) disable iff (!nrst)
        (!power_down_n |-> !serial_data_lanes_oe && !forwarded_link_clock_oe) and
        (!pd_lvl_reg |=> !drive_en_reg);
    endproperty
    a_pd_tristate: assert property (p_pd_tristate) else $error("outputs driven in power-down"); // [R07] [R09]

    property p_pd_reset;
        @(posedge clock) disable iff (!nrst)
        $fell(pd_lvl_reg) |=> standby_active && !link_locked ##1 !busy_reg && !fifo_out_valid;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("power-down did not reset the link"); // [R15]

    property p_no_clock_low;
        @(posedge clock) disable iff (!nrst)
        (state_reg == pixel_serializer_pkg::st_no_clock)[*2] |=> lane_out_reg == 3'h0 && !clk_out_reg;
    endproperty
    a_no_clock_low: assert property (p_no_clock_low) else $error("lanes not low without clock"); // [R06]

    property p_capture;
        @(posedge clock) disable iff (!nrst)
        fall_pulse && link_locked && fifo_in_ready |=> u_fifo.mem[$past(u_fifo.wr_ptr_reg)] == $past(pix_s3_reg);
    endproperty
    a_capture: assert property (p_capture) else $error("pixel word not captured"); // [R01] [R05]

    property p_lock_bound;
        @(posedge clock) disable iff (!nrst)
        int'(wait_cnt_reg) <= LOCK_TIME_LIMIT_CYCLES;
    endproperty
    a_lock_bound: assert property (p_lock_bound) else $error("lock took too long"); // [R10]

    property p_slot_walk;
        @(posedge clock) disable iff (!nrst)
        busy_reg && slot_reg != pixel_serializer_pkg::LAST_SLOT && !fifo_flush |=> slot_reg == $past(slot_reg) + 3'h1;
    endproperty
    a_slot_walk: assert property (p_slot_walk) else $error("slot sequence skipped"); // [R12]

    property p_lane_map;
        @(posedge clock) disable iff (!nrst)
        busy_reg && slot_reg == 3'h2 |=> lane_out_reg == {$past(word_reg[16]), $past(word_reg[9]), $past(word_reg[2])};
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane bit mapping wrong"); // [R02] [R17]

    property p_clk_pattern;
        @(posedge clock) disable iff (!nrst)
        busy_reg |=> clk_out_reg == pixel_serializer_pkg::CLK_SLOT_PATTERN[$past(slot_reg)];
    endproperty
    a_clk_pattern: assert property (p_clk_pattern) else $error("forwarded clock pattern wrong"); // [R03]

    property p_recover;
        @(posedge clock) disable iff (!nrst)
        link_locked && !clock_present && pd_lvl_reg |=> state_reg == pixel_serializer_pkg::st_no_clock;
    endproperty
    a_recover: assert property (p_recover) else $error("clock loss not handled"); // [R16]

    property p_release;
        @(posedge clock) disable iff (!nrst)
        standby_active && pd_lvl_reg |=> state_reg == pixel_serializer_pkg::st_no_clock;
    endproperty
    a_release: assert property (p_release) else $error("power-down release not taken"); // [R14]

    c_run: cover property (@(posedge clock) disable iff (!nrst) $rose(link_locked));
    c_standby: cover property (@(posedge clock) disable iff (!nrst) link_locked ##1 standby_active);
    c_loss: cover property (@(posedge clock) disable iff (!nrst) link_locked ##1 !clock_present);
    c_overrun: cover property (@(posedge clock) disable iff (!nrst) capture_overrun);
endmodule

// >>> src/pixel_serializer_pkg.sv
// Shared constants for the 7:1 pixel serializer and its word FIFO.
// Assumes a single 10 MHz system clock samples every pin of the block.
package pixel_serializer_pkg;
    // Word layout: 18 colour bits, then line sync, frame sync, pixel valid
    localparam int WORD_BITS = 21;
    localparam int COLOUR_BITS = 18;
    localparam int TIMING_BITS = 3;
    localparam int LINE_SYNC_BIT = 18;
    localparam int FRAME_SYNC_BIT = 19;
    localparam int PIXEL_VALID_BIT = 20;
    // Link shape: three data lanes, seven bit slots each
    localparam int LANES = 3;
    localparam int SLOTS = 7;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    // Forwarded clock level per slot, bit k is slot k
    localparam logic [6:0] CLK_SLOT_PATTERN = 7'h63;
    localparam int FIFO_DEPTH = 8;
    // System clock
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int SYS_PERIOD_NS = 100;
    // Outputs must be off within this time of power-down
    localparam int STANDBY_ENTRY_DELAY_NS = 100;
    localparam int STANDBY_ENTRY_CYCLES = (STANDBY_ENTRY_DELAY_NS / SYS_PERIOD_NS) < 1 ? 1 :
        STANDBY_ENTRY_DELAY_NS / SYS_PERIOD_NS;
    // Shortest recognised power-down pulse
    localparam int STANDBY_MIN_PULSE_US = 1;
    localparam int STANDBY_MIN_PULSE_CYCLES = (STANDBY_MIN_PULSE_US * 1000 + SYS_PERIOD_NS - 1) /
        SYS_PERIOD_NS;
    // Longest allowed time from clock present to valid output
    localparam int LOCK_TIME_LIMIT_MS = 10;
    localparam int LOCK_TIME_LIMIT_CYCLES = LOCK_TIME_LIMIT_MS * (SYS_CLK_HZ / 1000);
    // Cycles of steady clock before the link counts as locked
    localparam logic [6:0] LOCK_SETTLE_CYCLES = 7'h40;
    // Cycles without a falling edge before the clock counts as missing
    localparam logic [5:0] CLK_LOSS_CYCLES = 6'h20;
    typedef enum logic [1:0] {
        st_standby,
        st_no_clock,
        st_locking,
        st_run
    } link_state_e;
endpackage

// >>> src/pixel_word_fifo.sv
// Small synchronous FIFO holding captured pixel words before serializing.
// Assumes one clock domain; flush empties it in one cycle.
`timescale 1ns/100ps
module pixel_word_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshake: full and empty come straight from the count
    assign in_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_reg != '0) && !flush;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage, no reset needed since the count guards every read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> test/pixel_link_receiver.sv
// Far-end receiver model: rebuilds 21-bit words from three lanes and the clock lane.
// Assumes one slot per system clock, lanes idle low between words; samples at the
// falling system clock edge, half a slot after the slot is launched.
`timescale 1ns/100ps
module pixel_link_receiver (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [2:0] serial_data_lanes,
    input wire logic lanes_oe,
    input wire logic forwarded_link_clock,
    output logic [20:0] word_out,
    output logic word_strobe,
    output int n_clock_errors
);
    int slot;
    logic [20:0] acc;
    ////////////////////////////////////////////////////////////////////////////////
    // Word starts on a high clock lane after idle or after slot 6; a released lane aborts
    always @(negedge clock or negedge nrst) begin
        if (!nrst) begin
            slot = -1;
            acc = '0;
            word_out <= '0;
            word_strobe <= 1'h0;
            n_clock_errors = 0;
        end else begin
            word_strobe <= 1'h0;
            if (lanes_oe !== 1'h1) begin
                slot = -1; // Tri-stated wire carries nothing usable
            end else if (slot >= 0 || forwarded_link_clock === 1'h1) begin
                if (slot < 0) begin
                    slot = 0; // Falling-edge strobe receiver, no edge translation
                end
                if (forwarded_link_clock !== pixel_serializer_pkg::CLK_SLOT_PATTERN[slot]) begin
                    n_clock_errors++;
                end
                for (int n = 0; n < 3; n++) begin
                    acc[7 * n + slot] = serial_data_lanes[n]; // Same bit map as the sender
                end
                if (slot == 6) begin
                    word_out <= acc;
                    word_strobe <= 1'h1;
                    slot = -1;
                end else begin
                    slot++;
                end
            end
        end
    end
endmodule

// >>> test/pixel_serializer_7to1_bench.sv
// Self-checking bench for the 7:1 pixel serializer with a receiver model.
// Assumes the package constants and the receiver model in test/.
`timescale 1ns/100ps
module pixel_serializer_7to1_bench;
    logic clock;
    logic nrst;
    logic pix_clk;
    logic [20:0] pix_word;
    logic power_down_n;
    logic [2:0] lanes;
    logic lanes_oe;
    logic fclk;
    logic fclk_oe;
    logic locked;
    logic standby;
    logic overrun;
    logic [20:0] rx_word;
    logic rx_strobe;
    int clk_errs;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_ovr = 0;
    int dropped;
    int ovr_start;
    logic [31:0] seed = 32'h0000B7EA;
    logic [20:0] exp_q[$];
    logic [20:0] rx_q[$];
    pixel_serializer_7to1 #(.LOCK_TIME_LIMIT_CYCLES(200)) pixel_serializer_7to1_inst (.clock(clock), .nrst(nrst),
        .pixel_shift_clock_pin(pix_clk), .pixel_input_bits(pix_word), .power_down_n(power_down_n),
        .serial_data_lanes(lanes), .serial_data_lanes_oe(lanes_oe), .forwarded_link_clock(fclk),
        .forwarded_link_clock_oe(fclk_oe), .link_locked(locked), .standby_active(standby),
        .capture_overrun(overrun));
    pixel_link_receiver pixel_link_receiver_inst (.clock(clock), .nrst(nrst), .serial_data_lanes(lanes),
        .lanes_oe(lanes_oe), .forwarded_link_clock(fclk), .word_out(rx_word), .word_strobe(rx_strobe),
        .n_clock_errors(clk_errs));
    ////////////////////////////////////////////////////////////////////////////////
    // 10 MHz system clock
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    // Collect rebuilt words; zero filler words are not tracked
    always @(posedge clock) begin
        if (rx_strobe === 1'h1 && rx_word !== 21'h0) begin
            rx_q.push_back(rx_word);
        end
    end
    // Overrun pulses are counted half a cycle after launch, once settled
    always @(negedge clock) begin
        if (overrun === 1'h1) begin
            n_ovr++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
        total_checks++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, expected);
        end
    endtask
    // Pixel clock stands still low between bursts; word changes at the rise, well before the fall
    // Period is 800 ns unless a test stretches or squeezes it on purpose
    task automatic pixel_run(input int n, input int half, input bit record);
        @(negedge clock);
        for (int i = 0; i < n; i++) begin
            pix_clk = 1'h1;
            pix_word = record ? (21'(next_rand()) | 21'h100000) : 21'h0; // Colour plus timing bits
            if (record) begin
                exp_q.push_back(pix_word);
            end
            repeat (half) @(negedge clock);
            pix_clk = 1'h0;
            repeat (half) @(negedge clock);
        end
    endtask
    // Received words must be the sent ones in order, some possibly dropped
    task automatic match_words(output int lost);
        lost = 0;
        repeat (20) @(negedge clock);
        while (exp_q.size() > 0) begin
            if (rx_q.size() > 0 && rx_q[0] === exp_q[0]) begin
                void'(rx_q.pop_front());
            end else begin
                lost++;
            end
            void'(exp_q.pop_front());
        end
        check(rx_q.size(), 0, "unexpected words");
        rx_q.delete();
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'h0;
        pix_clk = 1'h0;
        pix_word = 21'h0;
        power_down_n = 1'h0;
        repeat (8) @(negedge clock);
        nrst = 1'h1;
        // Start-up in power-down, clock absent
        repeat (6) @(negedge clock);
        check(standby, 1, "standby");
        check(lanes_oe, 0, "lanes oe");
        power_down_n = 1'h1;
        repeat (10) @(negedge clock);
        check({lanes_oe, fclk_oe, lanes, fclk}, 32'h30, "no clock idle");
        $display("test startup done");
        // Lock, then a stream of words at 800 ns
        pixel_run(20, 4, 0);
        check(locked, 1, "locked");
        pixel_run(40, 4, 1);
        pixel_run(10, 4, 0);
        match_words(dropped);
        check(dropped, 0, "lost words");
        check(n_ovr, 0, "overrun");
        $display("test stream done");
        // Clock stops and resumes without power-down
        repeat (40) @(negedge clock);
        check({locked, lanes_oe, fclk_oe, lanes, fclk}, 32'h30, "clock loss");
        pixel_run(20, 4, 0);
        pixel_run(30, 4, 1);
        pixel_run(10, 5, 1); // Period drifts longer in mid-stream, as a spread clock does
        pixel_run(10, 4, 0);
        match_words(dropped);
        check(dropped, 0, "lost after resume");
        $display("test clock loss done");
        // Power-down in mid-stream
        fork
            pixel_run(30, 4, 1);
            begin
                repeat (100) @(negedge clock);
                power_down_n = 1'h0; // Held 12 cycles, above the minimum pulse
                @(negedge clock);
                check({lanes_oe, fclk_oe}, 0, "oe off");
                repeat (11) @(negedge clock);
                check({standby, locked}, 2, "standby");
                power_down_n = 1'h1;
            end
        join
        pixel_run(20, 4, 0);
        check(locked, 1, "relocked");
        pixel_run(20, 4, 1);
        pixel_run(10, 4, 0);
        match_words(dropped);
        check(dropped inside {[1:30]}, 1, "power-down loss");
        $display("test power down done");
        // Pixel clock faster than the link drains: FIFO fills and refuses
        ovr_start = n_ovr;
        pixel_run(80, 3, 1);
        pixel_run(20, 4, 0);
        match_words(dropped);
        check(n_ovr > ovr_start, 1, "fifo refused");
        check(dropped, n_ovr - ovr_start, "drop count");
        check(clk_errs, 0, "clock lane pattern");
        $display("test overrun done");
        stop_test();
    end
endmodule
